// File: hdl/sfs_fire.sv
`timescale 1ns/100ps
`include "sfs_regs.svh"
module sfs_fire import sfs_pkg::*; #(
  parameter int unsigned P_HALF_CLKS = `SFS_CLK_HZ / (2 * `SFS_LINE_HZ)
) (
  // Clock and reset
  input  wire logic  i_mclk,
  input  wire logic  i_rst_n,
  // Firing control
  sfs_fire_if.gen    fif
);
  localparam int CW = $clog2(P_HALF_CLKS + 1);

  logic [CW-1:0] cnt_reg;
  logic          active_reg;
  logic          fire_reg;
  wire  [47:0]   cnt_x100  = 48'(cnt_reg) * 48'(`SFS_PCT_FULL);
  wire  [47:0]   heat_span = 48'(fif.heat) * 48'(P_HALF_CLKS);
  wire           in_width  = cnt_x100 < heat_span;
  wire           cnt_end   = cnt_reg >= CW'(P_HALF_CLKS - 1);

  // Same width each line cycle, restarted on every tick while enabled
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_reg    <= '0;
      active_reg <= 1'b0;
      fire_reg   <= 1'b0;
    end else begin
      if (fif.tick && fif.enable) begin
        cnt_reg    <= '0;
        active_reg <= 1'b1;
      end else if (active_reg && !cnt_end && fif.enable) begin
        cnt_reg <= cnt_reg + CW'(1);
      end else begin
        active_reg <= 1'b0;
      end
      fire_reg <= fif.enable && active_reg && in_width;
    end
  end

  assign fif.fire = fire_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_fire_start;
    fif.tick && fif.enable && (fif.heat != 7'h00) ##1 fif.enable;
  endsequence
  property p_fire_start;
    s_fire_start |=> fif.fire;
  endproperty
  a_fire_start: assert property (p_fire_start) else $error("no firing at cycle start");
  property p_no_fire_idle;
    !fif.enable |=> !fif.fire;
  endproperty
  a_no_fire_idle: assert property (p_no_fire_idle) else $error("firing outside weld");
  property p_zero_heat;
    (fif.heat == 7'h00) && $stable(fif.heat) |=> !fif.fire;
  endproperty
  a_zero_heat: assert property (p_zero_heat) else $error("firing with zero heat");
endmodule // sfs_fire

// File: hdl/sfs_fire_if.sv
`timescale 1ns/100ps
interface sfs_fire_if;
  logic       tick;
  logic       enable;
  logic [6:0] heat;
  logic       fire;

  modport ctrl (output tick, output enable, output heat, input fire);
  modport gen  (input tick, input enable, input heat, output fire);
endinterface : sfs_fire_if

// File: hdl/sfs_pkg.sv
package sfs_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SQZ  = 6'h02,
    ST_CHK  = 6'h04,
    ST_WAIT = 6'h08,
    ST_WELD = 6'h10,
    ST_OFF  = 6'h20
  } sfs_state_e;

  typedef enum logic [1:0] {
    UNIT_PSI    = 2'h0,
    UNIT_MA     = 2'h1,
    UNIT_LB     = 2'h2,
    UNIT_CAL_LB = 2'h3
  } sfs_unit_e;

  typedef enum logic [1:0] {
    SENSE_OFF  = 2'h0,
    SENSE_RISE = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RSVD = 2'h3
  } sfs_sense_e;
endpackage : sfs_pkg

// File: hdl/sfs_regs.svh
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// Register word indices (byte address = 4 * index)
`define SFS_A_CTRL    4'h0
`define SFS_A_SETP    4'h1
`define SFS_A_HIGH    4'h2
`define SFS_A_LOW     4'h3
`define SFS_A_TRIG    4'h4
`define SFS_A_OFFS    4'h5
`define SFS_A_DIAM    4'h6
`define SFS_A_TIME    4'h7
`define SFS_A_STAT    4'h8
`define SFS_A_MASK    4'h9
`define SFS_A_MEAS    4'ha

// Control fields
`define SFS_C_START   0
`define SFS_C_VALVE   3:1
`define SFS_C_UNIT    5:4
`define SFS_C_MON     6
`define SFS_C_PRE     7
`define SFS_C_SENSE   9:8
`define SFS_CTRL_W    10

// Timing fields, in line cycles and percent
`define SFS_T_WELD    6:0
`define SFS_T_HEAT    14:8
`define SFS_T_SQZ     22:16
`define SFS_TIME_W    23

// Status and mask bits
`define SFS_S_HIGH    0
`define SFS_S_LOW     1
`define SFS_S_PREHI   2
`define SFS_S_PRELO   3
`define SFS_S_NRDY    4
`define SFS_S_TMO     5
`define SFS_S_DONE    6
`define SFS_STAT_W    7

// Value ranges: 0.1 PSI, microamps, half pounds
`define SFS_PSI_MAX   16'h03e8
`define SFS_MA_MIN    16'h0fa0
`define SFS_MA_MAX    16'h4e20
`define SFS_LB_MAX    16'h3d54
`define SFS_PCT_MAX   7'h63
`define SFS_PCT_FULL  24'h000064
`define SFS_LOOP_ZERO 16'h0fa0
`define SFS_LOOP_SH   4
`define SFS_AREA_K    15'h66f2
`define SFS_RST_ZERO  32'h0000_0000

// Timing
`define SFS_TIMEOUT_S 60
`define SFS_CLK_HZ    20000000
`define SFS_LINE_HZ   60

`endif

// File: hdl/sfs_top.sv
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "sfs_regs.svh"
// Function
// - Energise exactly selected valves during squeeze
// - Drive proportional valve with clamped setpoint
// - Loop current 4-20 mA maps 0-100 PSI
// - Force equals pressure times cylinder area
// - High and low force checks at squeeze end
// - Pre-limit check needs monitor and pre-limit enables
// - Pre-limits scale high down, low up
// - Offset whole percent 0 to 99
// - Sensing off skips check, advances at once
// - Rising sense waits for value at/above trigger
// - Falling sense waits for value at/below trigger
// - Sixty second wait abandons to off state
// - Trigger held in setpoint unit range
// - Weld current through first interval 0-99 cycles
// - Phase shift: same pulse width each cycle
// - Heat is percent 0-99 of maximum width
// - Intervals counted in line cycles
module sfs_top import sfs_pkg::*; #(
  parameter int unsigned P_TIMEOUT_CLKS = `SFS_TIMEOUT_S * `SFS_CLK_HZ,
  parameter int unsigned P_HALF_CLKS    = `SFS_CLK_HZ / (2 * `SFS_LINE_HZ)
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Line and sensor pins
  input  wire logic        i_line_zc,
  input  wire logic [15:0] i_sense_ua,
  // Valves and firing
  output logic      [2:0]  o_valve,
  output logic             o_pv_enable,
  output logic      [15:0] o_pv_setpoint,
  output logic      [1:0]  o_pv_unit,
  output logic             o_fire,
  // Flags
  output logic             o_valve_not_ready_flag,
  output logic             o_seq_off,
  output logic             o_irq
);
  function automatic logic [15:0] clamp_val(input logic [1:0] u, input logic [15:0] d,
                                            input logic [15:0] lbm);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = (u == UNIT_MA) ? `SFS_MA_MIN : 16'h0000;
    hi = (u == UNIT_PSI) ? `SFS_PSI_MAX : (u == UNIT_MA) ? `SFS_MA_MAX : lbm;
    clamp_val = (d < lo) ? lo : (d > hi) ? hi : d;
  endfunction

  function automatic logic [6:0] clamp_pct(input logic [6:0] d);
    clamp_pct = (d > `SFS_PCT_MAX) ? `SFS_PCT_MAX : d;
  endfunction

  sfs_state_e                  state_reg;
  sfs_state_e                  state_next;
  logic [`SFS_CTRL_W-1:0]      ctrl_reg;
  logic [15:0]                 setp_reg;
  logic [15:0]                 high_reg;
  logic [15:0]                 low_reg;
  logic [15:0]                 trig_reg;
  logic [6:0]                  offs_reg;
  logic [7:0]                  diam_reg;
  logic [`SFS_TIME_W-1:0]      time_reg;
  logic [`SFS_STAT_W-1:0]      stat_reg;
  logic [`SFS_STAT_W-1:0]      mask_reg;
  logic                        ack_reg;
  logic [31:0]                 rdata_reg;
  logic [2:0]                  zc_sync_reg;
  logic [15:0]                 sense_s1_reg;
  logic [15:0]                 sense_s2_reg;
  logic [6:0]                  cyc_cnt_reg;
  logic [31:0]                 tmo_cnt_reg;
  logic [2:0]                  valve_reg;
  logic                        pv_en_reg;
  logic [15:0]                 pv_setp_reg;
  logic                        nrdy_reg;

  // Bus decode
  wire        bus_req  = i_avs_read || i_avs_write;
  wire        wr_take  = i_avs_write && ack_reg;
  wire        rd_load  = i_avs_read && !ack_reg;
  wire        wr_ctrl  = wr_take && (i_avs_address == `SFS_A_CTRL);
  wire        wr_stat  = wr_take && (i_avs_address == `SFS_A_STAT);
  wire [1:0]  unit     = ctrl_reg[`SFS_C_UNIT];
  wire [1:0]  wr_unit  = wr_ctrl ? i_avs_writedata[`SFS_C_UNIT] : unit;
  wire        start    = wr_ctrl && i_avs_writedata[`SFS_C_START];

  // Measurement path
  wire [15:0] sense_ua  = sense_s2_reg;
  wire [15:0] loop_span = (sense_ua >= `SFS_LOOP_ZERO) ? (sense_ua - `SFS_LOOP_ZERO) : 16'h0000;
  wire [15:0] psi10     = loop_span >> `SFS_LOOP_SH;
  wire [15:0] diam_sq   = 16'(diam_reg) * 16'(diam_reg);
  wire [43:0] force_pr  = 44'(psi10) * 44'(diam_sq) * 44'(`SFS_AREA_K);
  wire [15:0] force_hl  = force_pr[39:24];
  // Lb ceiling is full-scale force, at most SFS_LB_MAX; program the diameter first
  wire [43:0] cap_pr    = 44'(`SFS_PSI_MAX) * 44'(diam_sq) * 44'(`SFS_AREA_K);
  wire [15:0] lb_cap    = (cap_pr[43:24] > 20'(`SFS_LB_MAX)) ? `SFS_LB_MAX : cap_pr[39:24];
  wire [15:0] wr_val    = clamp_val(wr_unit, i_avs_writedata[15:0], lb_cap);
  wire [15:0] meas      = (unit == UNIT_MA) ? sense_ua :
                          (unit == UNIT_PSI) ? psi10 : force_hl;

  // Limit and trigger comparisons
  wire        mon_en    = ctrl_reg[`SFS_C_MON];
  wire        pre_en    = ctrl_reg[`SFS_C_PRE] && mon_en;
  wire [1:0]  sense     = ctrl_reg[`SFS_C_SENSE];
  wire [23:0] meas_x100 = 24'(meas) * `SFS_PCT_FULL;
  wire [23:0] prehi_thr = 24'(high_reg) * (`SFS_PCT_FULL - 24'(offs_reg));
  wire [23:0] prelo_thr = 24'(low_reg) * (`SFS_PCT_FULL + 24'(offs_reg));
  wire        in_chk    = state_reg == ST_CHK;
  wire        in_wait   = state_reg == ST_WAIT;
  wire        hit_high  = in_chk && mon_en && (meas >= high_reg);
  wire        hit_low   = in_chk && mon_en && (meas <= low_reg);
  wire        hit_prehi = in_chk && pre_en && (meas_x100 >= prehi_thr);
  wire        hit_prelo = in_chk && pre_en && (meas_x100 <= prelo_thr);
  wire        sense_on  = (sense == SENSE_RISE) || (sense == SENSE_FALL);
  wire        trig_ok   = (sense == SENSE_RISE) ? (meas >= trig_reg) : (meas <= trig_reg);
  wire        tmo_hit   = tmo_cnt_reg >= 32'(P_TIMEOUT_CLKS - 1);

  // Line cycle tick and interval ends
  wire        line_tick = zc_sync_reg[1] && !zc_sync_reg[2];
  wire        sqz_end   = cyc_cnt_reg >= time_reg[`SFS_T_SQZ];
  // Ends on the tick after the last full cycle, so no pulse is cut short
  wire        weld_end  = (time_reg[`SFS_T_WELD] == 7'h00) ||
                          (line_tick && (cyc_cnt_reg >= time_reg[`SFS_T_WELD]));
  wire        valve_on  = (state_next == ST_SQZ) || (state_next == ST_CHK) ||
                          (state_next == ST_WAIT) || (state_next == ST_WELD);

  // Sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (start) state_next = ST_SQZ;
      ST_SQZ:  if (sqz_end) state_next = ST_CHK;
      ST_CHK: begin
        if (!sense_on || trig_ok) begin
          state_next = ST_WELD;
        end else begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trig_ok) begin
          state_next = ST_WELD;
        end else if (tmo_hit) begin
          state_next = ST_OFF;
        end
      end
      ST_WELD: if (weld_end) state_next = ST_IDLE;
      ST_OFF:  if (start) state_next = ST_SQZ;
    endcase
  end

  wire [`SFS_STAT_W-1:0] stat_set = {
    (state_reg == ST_WELD) && weld_end,
    in_wait && !trig_ok && tmo_hit,
    in_wait,
    hit_prelo,
    hit_prehi,
    hit_low,
    hit_high
  };
  wire [`SFS_STAT_W-1:0] stat_clr = wr_stat ? i_avs_writedata[`SFS_STAT_W-1:0] : '0;

  wire [31:0] rd_mux =
    (i_avs_address == `SFS_A_CTRL) ? 32'(ctrl_reg) :
    (i_avs_address == `SFS_A_SETP) ? 32'(setp_reg) :
    (i_avs_address == `SFS_A_HIGH) ? 32'(high_reg) :
    (i_avs_address == `SFS_A_LOW)  ? 32'(low_reg) :
    (i_avs_address == `SFS_A_TRIG) ? 32'(trig_reg) :
    (i_avs_address == `SFS_A_OFFS) ? 32'(offs_reg) :
    (i_avs_address == `SFS_A_DIAM) ? 32'(diam_reg) :
    (i_avs_address == `SFS_A_TIME) ? 32'(time_reg) :
    (i_avs_address == `SFS_A_STAT) ? 32'(stat_reg) :
    (i_avs_address == `SFS_A_MASK) ? 32'(mask_reg) :
    (i_avs_address == `SFS_A_MEAS) ? {10'h000, state_reg, meas} : `SFS_RST_ZERO;

  // Bus slave: one wait state for every access
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= `SFS_RST_ZERO;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (rd_load) rdata_reg <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_reg <= '0;
      setp_reg <= '0;
      high_reg <= '0;
      low_reg  <= '0;
      trig_reg <= '0;
      offs_reg <= '0;
      diam_reg <= '0;
      time_reg <= '0;
      mask_reg <= '0;
    end else if (wr_take) begin
      unique case (i_avs_address)
        `SFS_A_CTRL: ctrl_reg <= {i_avs_writedata[`SFS_CTRL_W-1:1], 1'b0};
        `SFS_A_SETP: setp_reg <= wr_val;
        `SFS_A_HIGH: high_reg <= wr_val;
        `SFS_A_LOW:  low_reg  <= wr_val;
        `SFS_A_TRIG: trig_reg <= wr_val;
        `SFS_A_OFFS: offs_reg <= clamp_pct(i_avs_writedata[6:0]);
        `SFS_A_DIAM: diam_reg <= i_avs_writedata[7:0];
        `SFS_A_TIME: time_reg <= {clamp_pct(i_avs_writedata[22:16]), 1'b0,
                                  clamp_pct(i_avs_writedata[14:8]), 1'b0,
                                  clamp_pct(i_avs_writedata[6:0])};
        `SFS_A_MASK: mask_reg <= i_avs_writedata[`SFS_STAT_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
    end
  end

  // Pin synchronisers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      zc_sync_reg  <= '0;
      sense_s1_reg <= '0;
      sense_s2_reg <= '0;
    end else begin
      zc_sync_reg  <= {zc_sync_reg[1:0], i_line_zc};
      sense_s1_reg <= i_sense_ua;
      sense_s2_reg <= sense_s1_reg;
    end
  end

  // State, interval and timeout counters
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_reg   <= ST_IDLE;
      cyc_cnt_reg <= '0;
      tmo_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cyc_cnt_reg <= '0;
      end else if (line_tick) begin
        cyc_cnt_reg <= cyc_cnt_reg + 7'h01;
      end
      tmo_cnt_reg <= in_wait ? tmo_cnt_reg + 32'h0000_0001 : '0;
    end
  end

  // Valve and flag outputs
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      valve_reg   <= '0;
      pv_en_reg   <= 1'b0;
      pv_setp_reg <= '0;
      nrdy_reg    <= 1'b0;
    end else begin
      valve_reg   <= valve_on ? ctrl_reg[`SFS_C_VALVE] : 3'h0;
      pv_en_reg   <= valve_on;
      pv_setp_reg <= valve_on ? setp_reg : 16'h0000;
      nrdy_reg    <= state_next == ST_WAIT;
    end
  end

  sfs_fire_if fire_if ();

  assign fire_if.tick   = line_tick;
  assign fire_if.enable = state_reg == ST_WELD;
  assign fire_if.heat   = time_reg[`SFS_T_HEAT];

  sfs_fire #(
    .P_HALF_CLKS (P_HALF_CLKS)
  ) u_fire (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .fif     (fire_if.gen)
  );

  assign o_avs_readdata         = rdata_reg;
  assign o_avs_waitrequest      = bus_req && !ack_reg;
  assign o_valve                = valve_reg;
  assign o_pv_enable            = pv_en_reg;
  assign o_pv_setpoint          = pv_setp_reg;
  assign o_pv_unit              = unit;
  assign o_fire                 = fire_if.fire;
  assign o_valve_not_ready_flag = nrdy_reg;
  assign o_seq_off              = state_reg == ST_OFF;
  assign o_irq                  = |(stat_reg & mask_reg);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  wire act = (state_reg == ST_SQZ) || in_chk || in_wait || (state_reg == ST_WELD);

  property p_valve_sel;
    act |-> (o_valve == $past(ctrl_reg[`SFS_C_VALVE]));
  endproperty
  a_valve_sel: assert property (p_valve_sel) else $error("valve set mismatch");
  property p_high_err;
    hit_high |=> stat_reg[`SFS_S_HIGH];
  endproperty
  a_high_err: assert property (p_high_err) else $error("high error missed");
  property p_low_err;
    in_chk && mon_en && (meas <= low_reg) |=> stat_reg[`SFS_S_LOW];
  endproperty
  a_low_err: assert property (p_low_err) else $error("low error missed");
  property p_pre_gate;
    $rose(stat_reg[`SFS_S_PREHI]) |-> $past(in_chk && ctrl_reg[`SFS_C_PRE] && mon_en);
  endproperty
  a_pre_gate: assert property (p_pre_gate) else $error("pre-high without enables");
  property p_sense_off;
    in_chk && (sense == SENSE_OFF) |=> (state_reg == ST_WELD);
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sensing off did not advance");
  property p_rise_wait;
    in_chk && (sense == SENSE_RISE) && (meas < trig_reg) |=>
      in_wait && o_valve_not_ready_flag;
  endproperty
  a_rise_wait: assert property (p_rise_wait) else $error("rising wait not entered");
  property p_fall_adv;
    in_wait && (sense == SENSE_FALL) && (meas <= trig_reg) |=> (state_reg == ST_WELD);
  endproperty
  a_fall_adv: assert property (p_fall_adv) else $error("falling wait did not advance");
  sequence s_timeout;
    in_wait && tmo_hit && !trig_ok;
  endsequence
  property p_timeout;
    s_timeout |=> o_seq_off && stat_reg[`SFS_S_TMO] && (o_valve == 3'h0);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not taken");
  property p_sticky;
    stat_reg[`SFS_S_LOW] && !stat_clr[`SFS_S_LOW] |=> stat_reg[`SFS_S_LOW];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");
endmodule // sfs_top

// File: verif/sfs_plant_model.sv
`timescale 1ns/100ps
module sfs_plant_model #(
  parameter int unsigned P_HALF_CLKS = 20
) (
  // Clock
  input  wire logic        i_mclk,
  // Device side
  input  wire logic [2:0]  i_valve,
  input  wire logic [15:0] i_level_ua,
  output logic             o_line_zc,
  output logic      [15:0] o_sense_ua
);
  int unsigned half_cnt_reg = 0;

  initial o_line_zc = 1'b0;

  // Mains runs free, one rising zero cross per line cycle
  always @(posedge i_mclk) begin
    if (half_cnt_reg == P_HALF_CLKS - 1) begin
      half_cnt_reg <= 0;
      o_line_zc    <= ~o_line_zc;
    end else begin
      half_cnt_reg <= half_cnt_reg + 1;
    end
  end

  // No pressure builds without an energised cylinder valve: 4 mA
  assign o_sense_ua = (|i_valve) ? i_level_ua : 16'h0fa0;
endmodule // sfs_plant_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
`include "sfs_regs.svh"
module tb_top;
  logic        i_mclk        = 1'b0;
  logic        i_rst_n       = 1'b0;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] level_ua      = 16'h2ee0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic        line_zc;
  logic [15:0] sense_ua;
  logic [2:0]  o_valve;
  logic        o_pv_enable;
  logic [15:0] o_pv_setpoint;
  logic [1:0]  o_pv_unit;
  logic        o_fire;
  logic        o_valve_not_ready_flag;
  logic        o_seq_off;
  logic        o_irq;
  logic [35:0] exp_q[$];
  logic [35:0] note;
  int          n_errors = 0;
  int          checks   = 0;
  int          seed     = 79867;
  int          fire_len = 0;
  int          exp_w    = 0;

  sfs_top #(.P_TIMEOUT_CLKS(200), .P_HALF_CLKS(20)) uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_line_zc(line_zc), .i_sense_ua(sense_ua), .o_valve(o_valve),
    .o_pv_enable(o_pv_enable), .o_pv_setpoint(o_pv_setpoint), .o_pv_unit(o_pv_unit),
    .o_fire(o_fire), .o_valve_not_ready_flag(o_valve_not_ready_flag),
    .o_seq_off(o_seq_off), .o_irq(o_irq));

  sfs_plant_model #(.P_HALF_CLKS(20)) plant (
    .i_mclk(i_mclk), .i_valve(o_valve), .i_level_ua(level_ua),
    .o_line_zc(line_zc), .o_sense_ua(sense_ua));

  always #25 i_mclk = ~i_mclk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Oldest read note against data of each accepted read
  always @(posedge i_mclk) begin
    if (avs_read && !o_avs_waitrequest && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk($sformatf("reg %0h", note[35:32]), o_avs_readdata, note[31:0]);
    end
  end

  always @(negedge i_mclk) begin
    if (o_fire === 1'b1) begin
      fire_len++;
    end else if (fire_len != 0) begin
      chk("fire width", fire_len, exp_w);
      fire_len = 0;
    end
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic wt;
    int   k;
    wt = 1'b1;
    @(posedge i_mclk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    for (k = 0; k < 50 && wt; k++) begin
      @(posedge i_mclk);
      wt = o_avs_waitrequest;
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (wt) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back({a, e});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_on(input int sel, input logic v);
    int k;
    for (k = 0; k < 4000; k++) begin
      @(negedge i_mclk);
      if ((sel == 0 ? o_pv_enable : o_valve_not_ready_flag) === v) return;
    end
    n_errors++;
    print_verdict();
  endtask

  task automatic run(input logic [9:0] cfg, input logic [15:0] nl, input logic [6:0] es);
    wr(`SFS_A_CTRL, {22'h0, cfg});
    rd(`SFS_A_CTRL, {22'h0, cfg});
    wr(`SFS_A_CTRL, {22'h0, cfg | 10'h001});
    wait_on(0, 1'b1);
    chk("valves", o_valve, cfg[3:1]);
    chk("setpoint", o_pv_setpoint, 16'h0100);
    chk("unit", o_pv_unit, cfg[5:4]);
    if (nl != 16'h0) begin
      wait_on(1, 1'b1);
      @(posedge i_mclk);
      level_ua <= nl;
    end
    wait_on(0, 1'b0);
    chk("valves off", o_valve, 3'h0);
    chk("off state", o_seq_off, es[5]);
    chk("irq", o_irq, es[6]);
    rd(`SFS_A_STAT, {25'h0, es});
    wr(`SFS_A_STAT, 32'h7f);
    level_ua <= 16'h2ee0;
    @(negedge i_mclk);
    chk("irq clear", o_irq, 1'b0);
  endtask

  task automatic row(input logic [9:0] cfg, input logic [15:0] h, input logic [15:0] l,
                     input logic [6:0] o, input logic [6:0] es);
    wr(`SFS_A_CTRL, {22'h0, cfg});
    wr(`SFS_A_HIGH, {16'h0, h});
    wr(`SFS_A_LOW, {16'h0, l});
    wr(`SFS_A_OFFS, {25'h0, o});
    run(cfg, 16'h0, es);
  endtask

  initial begin
    logic [31:0] v;
    int          i;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(`SFS_A_STAT, 32'h0);
    rd(`SFS_A_MEAS, 32'h0001_0000);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`SFS_A_SETP, v);
      rd(`SFS_A_SETP, {16'h0, (v[15:0] > 16'h03e8) ? 16'h03e8 : v[15:0]});
    end
    wr(`SFS_A_OFFS, 32'h7f);
    rd(`SFS_A_OFFS, 32'h63);
    wr(`SFS_A_TIME, 32'h007f_7f7f);
    rd(`SFS_A_TIME, 32'h0063_6363);
    wr(`SFS_A_SETP, 32'h100);
    wr(`SFS_A_DIAM, 32'h14);
    wr(`SFS_A_MASK, 32'h40);
    rd(`SFS_A_MASK, 32'h40);
    $display("test registers done");
    // Squeeze 1, heat 50 percent, weld 2 cycles
    wr(`SFS_A_TIME, 32'h0001_3202);
    exp_w = 10;
    for (i = 0; i < 8; i++) begin
      run({6'h0, i[2:0], 1'b0}, 16'h0, 7'h40);
    end
    wr(`SFS_A_TIME, 32'h0001_0002);
    exp_w = 0;
    run(10'h002, 16'h0, 7'h40);
    exp_w = 10;
    wr(`SFS_A_TIME, 32'h0001_3202);
    $display("test valves done");
    row(10'h042, 16'h01f4, 16'h0064, 7'h00, 7'h41);
    row(10'h042, 16'h0258, 16'h01f4, 7'h00, 7'h42);
    row(10'h0c2, 16'h0208, 16'h0064, 7'h05, 7'h44);
    row(10'h0c2, 16'h0258, 16'h01e0, 7'h05, 7'h48);
    row(10'h082, 16'h01f4, 16'h01f4, 7'h05, 7'h40);
    row(10'h042, 16'h0208, 16'h0064, 7'h05, 7'h40);
    row(10'h062, 16'h013a, 16'h0000, 7'h00, 7'h41);
    row(10'h062, 16'h013b, 16'h0000, 7'h00, 7'h40);
    wr(`SFS_A_TRIG, 32'hffff);
    rd(`SFS_A_TRIG, 32'h0274);
    row(10'h052, 16'h2ee0, 16'h0fa0, 7'h00, 7'h41);
    $display("test limits done");
    wr(`SFS_A_TIME, 32'h0001_1902);
    exp_w = 5;
    wr(`SFS_A_CTRL, 32'h102);
    wr(`SFS_A_TRIG, 32'h258);
    run(10'h102, 16'h36b0, 7'h50);
    wr(`SFS_A_CTRL, 32'h202);
    wr(`SFS_A_TRIG, 32'h190);
    run(10'h202, 16'h1f40, 7'h50);
    run(10'h202, 16'h0, 7'h30);
    $display("test sensing done");
    print_verdict();
  end
endmodule // tb_top
